// >>> logic/rmlb_pkg.sv
// Purpose: Shared constants and types for repeater maintenance loopback
// Assumes: 10 MHz reference clock, one clock domain
// Notes:   Message codes and register layouts are local choices
package rmlb_pkg;

    // ==============================================================
    // Timing
    localparam int unsigned DEACT_TIME_MS  = 2000;
    localparam int unsigned CLK_HZ         = 10000000;
    localparam int unsigned DEACT_CYCLES   = DEACT_TIME_MS * (CLK_HZ / 1000);

    // ==============================================================
    // Addresses and message codes
    localparam logic [1:0] ADDR_REPEATER   = 2'h2;
    localparam logic [1:0] ADDR_NET_TERM   = 2'h3;
    localparam logic [3:0] MSG_LOOP_REQ    = 4'h1;
    localparam logic [3:0] MSG_RESTORE     = 4'h2;
    localparam logic [3:0] MSG_WAIT_REPLY  = 4'h3;
    localparam logic [3:0] MSG_STATUS_REQ  = 4'h4;
    localparam logic [3:0] MSG_STATUS_RSP  = 4'h5;
    localparam logic [3:0] MSG_CFG_WR      = 4'h6;
    localparam logic [3:0] MSG_ACK         = 4'h7;

    // ==============================================================
    // Overhead indicator bit positions
    localparam int unsigned OH_W           = 8;
    localparam int unsigned OH_PRESENCE    = 0;
    localparam int unsigned OH_REP_ALARM   = 1;
    localparam int unsigned OH_RX_BLK_ERR  = 2;
    localparam int unsigned OH_CUST_BLK_ERR = 3;
    localparam int unsigned OH_RT_ALARM    = 4;
    localparam int unsigned OH_PWR_ONE     = 5;
    localparam int unsigned OH_PWR_TWO     = 6;
    localparam int unsigned OH_APP_LOSS    = 7;
    localparam logic [7:0]  OH_LOCAL_MASK  = 8'h0F;

    // ==============================================================
    // Controller registers
    localparam logic [3:0] REG_CTRL        = 4'h0;
    localparam logic [3:0] REG_STATUS      = 4'h4;
    localparam logic [3:0] REG_RSP         = 4'h8;
    localparam logic [3:0] REG_CFG         = 4'hC;
    localparam logic [7:0] CFG_RESET       = 8'h00;

    typedef enum logic [0:0] {RMLB_DIR_NONE, RMLB_DIR_BUSY} rmlb_dummy_t;

endpackage

// >>> logic/rmlb_if.sv
// Purpose: Link between line termination controller and repeater
// Assumes: Both ends on ref_clk_in
// Notes:   Messages are one-cycle strobes with address, code and data
`timescale 1ns/1ns
interface rmlb_if;
    logic       dn_msg_vld;
    logic [1:0] dn_msg_addr;
    logic [3:0] dn_msg_code;
    logic [7:0] dn_msg_data;
    logic       up_msg_vld;
    logic [1:0] up_msg_addr;
    logic [3:0] up_msg_code;
    logic [7:0] up_msg_data;
    logic       startup_tx;
    logic       line_active;
    logic [7:0] dn_oh_bits;
    logic [7:0] up_oh_bits;
    logic       path_id_valid;

    modport line_term (
        output dn_msg_vld, dn_msg_addr, dn_msg_code, dn_msg_data,
        output startup_tx, dn_oh_bits,
        input  up_msg_vld, up_msg_addr, up_msg_code, up_msg_data,
        input  line_active, up_oh_bits, path_id_valid
    );
    modport rep (
        input  dn_msg_vld, dn_msg_addr, dn_msg_code, dn_msg_data,
        input  startup_tx, dn_oh_bits,
        output up_msg_vld, up_msg_addr, up_msg_code, up_msg_data,
        output line_active, up_oh_bits, path_id_valid
    );
endinterface

// >>> logic/rmlb_persist.sv
// Purpose: Qualifies a fault level that must persist a set time
// Assumes: Input already synchronised
// Notes:   Output rises after LIMIT consecutive cycles high
`timescale 1ns/1ns
module rmlb_persist #(
    parameter int unsigned LIMIT = 20000000
) (
    input  wire logic ref_clk_in,    // Clock
    input  wire logic rst_in,        // Async reset
    input  wire logic level_in,      // Fault level
    output logic      persist_out    // Fault persisted
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        hit;
    } rmlb_pst_t;

    rmlb_pst_t st_ff;
    rmlb_pst_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!level_in) begin
            nxt_st.cnt = 32'h0;
            nxt_st.hit = 1'b0;
        end else if (st_ff.cnt >= LIMIT - 1) begin
            nxt_st.hit = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign persist_out = st_ff.hit;
endmodule

// >>> logic/rmlb_repeater.sv
// Purpose: Repeater maintenance control with network-side loopback
// Assumes: Fault and alarm pins are asynchronous; messages synchronous
// Notes:   Principal file; uses rmlb_persist for the deactivation delay
`timescale 1ns/1ns
module rmlb_repeater #(
    parameter int unsigned DEACT_CYCLES = rmlb_pkg::DEACT_CYCLES,
    parameter bit          APP_BITS_EN  = 1'b0
) (
    input  wire logic ref_clk_in,        // Clock
    input  wire logic rst_in,            // Async reset
    rmlb_if.rep       lnk,               // Line side link
    input  wire logic net_fault_in,      // Line side loss/align fault
    input  wire logic cust_fault_in,     // Customer side loss/align fault
    input  wire logic int_fail_in,       // Internal failure
    input  wire logic pwr_fail_one_in,   // Power source one failed
    input  wire logic pwr_fail_two_in,   // Power source two failed
    input  wire logic app_loss_in,       // Application signal loss
    input  wire logic rx_blk_err_in,     // Local receive block error
    input  wire logic cust_blk_err_in,   // Local customer block error
    input  wire logic [7:0] cust_oh_in,  // Bits from network unit side
    output logic      net_side_on_out,   // Line side transceiver on
    output logic      cust_side_on_out,  // Customer side transceiver on
    output logic      cust_reset_out,    // Customer transceiver reset
    output logic      loop_closed_out,   // Loopback active
    output logic      fwd_to_ntu_out,    // Forwarding toward network unit
    output logic [7:0] cfg_out           // Configuration register
);
    typedef struct packed {
        logic [5:0] sync_a;
        logic [5:0] sync_b;
        logic       net_on;
        logic       cust_on;
        logic       cust_rst;
        logic       loop;
        logic [7:0] cfg;
        logic       rsp_vld;
        logic [1:0] rsp_addr;
        logic [3:0] rsp_code;
        logic [7:0] rsp_data;
        logic [7:0] up_oh;
    } rmlb_rep_t;

    rmlb_rep_t st_ff;
    rmlb_rep_t nxt_st;
    logic      fault_lvl;
    logic      fault_hit;
    logic [7:0] status;
    logic [7:0] local_oh;
    logic [7:0] term_oh;

    // ==============================================================
    // Fault qualification
    // Both line faults share one timer; either one drops both sides
    assign fault_lvl = st_ff.sync_b[0] | st_ff.sync_b[1];

    rmlb_persist #(.LIMIT(DEACT_CYCLES)) u_persist (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .level_in    (fault_lvl),
        .persist_out (fault_hit)
    );

    always_comb begin
        local_oh = 8'h00;
        local_oh[rmlb_pkg::OH_PRESENCE]     = st_ff.net_on;
        local_oh[rmlb_pkg::OH_REP_ALARM]    = st_ff.sync_b[2];
        local_oh[rmlb_pkg::OH_RX_BLK_ERR]   = rx_blk_err_in;
        local_oh[rmlb_pkg::OH_CUST_BLK_ERR] = cust_blk_err_in;
        // terminal indicator bits
        // Application bits only where the APP_BITS_EN parameter enables them
        term_oh = 8'h00;
        term_oh[rmlb_pkg::OH_PWR_ONE] = st_ff.sync_b[3];
        term_oh[rmlb_pkg::OH_PWR_TWO] = st_ff.sync_b[4];
        term_oh[rmlb_pkg::OH_APP_LOSS] = st_ff.sync_b[5] & APP_BITS_EN;
        status = {4'h0, st_ff.loop, st_ff.cust_on, st_ff.net_on,
                  st_ff.sync_b[2]};
    end

    // ==============================================================
    // Control
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync_a = {app_loss_in, pwr_fail_two_in, pwr_fail_one_in,
                         int_fail_in, cust_fault_in, net_fault_in};
        nxt_st.sync_b = st_ff.sync_a;
        nxt_st.rsp_vld = 1'b0;
        nxt_st.cust_rst = 1'b0;
        if (lnk.dn_msg_vld) begin
            if (lnk.dn_msg_addr == rmlb_pkg::ADDR_REPEATER) begin
                case (lnk.dn_msg_code)
                    rmlb_pkg::MSG_LOOP_REQ: begin
                        nxt_st.loop = 1'b1;
                        nxt_st.cust_rst = 1'b1;
                        nxt_st.rsp_vld = 1'b1;
                        nxt_st.rsp_code = rmlb_pkg::MSG_ACK;
                    end
                    rmlb_pkg::MSG_RESTORE: begin
                        nxt_st.loop = 1'b0;
                        nxt_st.cust_on = 1'b0;
                        nxt_st.rsp_vld = 1'b1;
                        nxt_st.rsp_code = rmlb_pkg::MSG_ACK;
                    end
                    rmlb_pkg::MSG_STATUS_REQ: begin
                        nxt_st.rsp_vld = 1'b1;
                        nxt_st.rsp_code = rmlb_pkg::MSG_STATUS_RSP;
                    end
                    rmlb_pkg::MSG_CFG_WR: begin
                        nxt_st.cfg = lnk.dn_msg_data;
                        nxt_st.rsp_vld = 1'b1;
                        nxt_st.rsp_code = rmlb_pkg::MSG_ACK;
                    end
                    default: begin
                        nxt_st.rsp_vld = 1'b0;
                    end
                endcase
            end else if (st_ff.loop) begin
                nxt_st.rsp_vld = 1'b1;
                nxt_st.rsp_code = rmlb_pkg::MSG_WAIT_REPLY;
            end
        end
        nxt_st.rsp_addr = rmlb_pkg::ADDR_REPEATER;
        nxt_st.rsp_data = status;
        // restart customer link
        // Waits for a quiet channel so a new request wins
        if (!st_ff.loop && st_ff.net_on && !st_ff.cust_on &&
            !nxt_st.loop && !lnk.dn_msg_vld) begin
            nxt_st.cust_on = 1'b1;
        end
        if (!st_ff.net_on && lnk.startup_tx && !fault_lvl) begin
            nxt_st.net_on = 1'b1;
        end
        if (fault_hit) begin
            nxt_st.net_on = 1'b0;
            nxt_st.cust_on = 1'b0;
            nxt_st.loop = 1'b0;
        end
        if (st_ff.loop) begin
            nxt_st.up_oh = (lnk.dn_oh_bits & ~rmlb_pkg::OH_LOCAL_MASK) |
                           (local_oh & rmlb_pkg::OH_LOCAL_MASK);
        end else begin
            // Terminal bits yield to the looped copy while closed
            nxt_st.up_oh = ((cust_oh_in | term_oh) &
                            ~rmlb_pkg::OH_LOCAL_MASK) |
                           (local_oh & rmlb_pkg::OH_LOCAL_MASK);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==============================================================
    // Outputs
    assign lnk.up_msg_vld    = st_ff.rsp_vld;
    assign lnk.up_msg_addr   = st_ff.rsp_addr;
    assign lnk.up_msg_code   = st_ff.rsp_code;
    assign lnk.up_msg_data   = st_ff.rsp_data;
    assign lnk.up_oh_bits    = st_ff.up_oh;
    assign lnk.line_active   = st_ff.net_on;
    // Path id valid whenever the far end sees a closed path
    assign lnk.path_id_valid = st_ff.net_on & (st_ff.loop | st_ff.cust_on);
    assign net_side_on_out   = st_ff.net_on;
    assign cust_side_on_out  = st_ff.cust_on;
    assign cust_reset_out    = st_ff.cust_rst;
    assign loop_closed_out   = st_ff.loop;
    assign fwd_to_ntu_out    = st_ff.cust_on | st_ff.loop;
    assign cfg_out           = st_ff.cfg;
endmodule

// >>> logic/rmlb_ltu.sv
// Purpose: Line termination maintenance controller end
// Assumes: Software port with one-cycle read latency
// Notes:   Terminal alarm, power and app bits come in overhead
`timescale 1ns/1ns
module rmlb_line_term (
    input  wire logic       ref_clk_in,   // Clock
    input  wire logic       rst_in,       // Async reset
    rmlb_if.line_term       lnk,          // Link to repeater
    input  wire logic [3:0] addr_in,      // Register address
    input  wire logic [7:0] wdata_in,     // Write data
    input  wire logic       wr_in,        // Write strobe
    input  wire logic       rd_in,        // Read strobe
    output logic [7:0]      rdata_out     // Read data
);
    typedef struct packed {
        logic       startup;
        logic       send;
        logic [1:0] addr;
        logic [3:0] code;
        logic [7:0] data;
        logic [7:0] rsp;
        logic [7:0] cfg;
        logic [7:0] rdata;
    } rmlb_line_term_t;

    rmlb_line_term_t st_ff;
    rmlb_line_term_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.send = 1'b0;
        if (wr_in && addr_in == rmlb_pkg::REG_CTRL) begin
            nxt_st.startup = wdata_in[7];
            // request only once startup signal sent or line active
            if (wdata_in[7] || st_ff.startup || lnk.line_active) begin
                nxt_st.send = wdata_in[6];
                nxt_st.addr = wdata_in[5:4];
                nxt_st.code = wdata_in[3:0];
                nxt_st.data = st_ff.cfg;
            end
        end
        if (wr_in && addr_in == rmlb_pkg::REG_CFG) begin
            nxt_st.cfg = wdata_in;
        end
        if (lnk.up_msg_vld) begin
            nxt_st.rsp = {lnk.up_msg_code, 2'h0, lnk.up_msg_addr};
        end
        nxt_st.rdata = 8'h00;
        if (rd_in) begin
            case (addr_in)
                rmlb_pkg::REG_CTRL:   nxt_st.rdata = {st_ff.startup, 7'h00};
                // path id confirms loop and restart
                rmlb_pkg::REG_STATUS: nxt_st.rdata = {lnk.up_oh_bits[7:2],
                                          lnk.path_id_valid,
                                          lnk.line_active};
                rmlb_pkg::REG_RSP:    nxt_st.rdata = st_ff.rsp;
                rmlb_pkg::REG_CFG:    nxt_st.rdata = st_ff.cfg;
                default:              nxt_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign lnk.startup_tx  = st_ff.startup;
    assign lnk.dn_msg_vld  = st_ff.send;
    assign lnk.dn_msg_addr = st_ff.addr;
    assign lnk.dn_msg_code = st_ff.code;
    assign lnk.dn_msg_data = st_ff.data;
    assign lnk.dn_oh_bits  = st_ff.cfg;
    assign rdata_out       = st_ff.rdata;
endmodule

// >>> verif/rmlb_assertions.sv
// Purpose: Concurrent checks across the repeater maintenance link
// Assumes: One clock, rst_in active high and asynchronous
// Notes:   Sees link signals and repeater outputs as plain inputs
`timescale 1ns/1ns
module rmlb_assertions (
    input wire logic       ref_clk_in,       // Clock
    input wire logic       rst_in,           // Async reset
    input wire logic       dn_msg_vld,       // Downstream message strobe
    input wire logic [1:0] dn_msg_addr,      // Downstream address
    input wire logic [3:0] dn_msg_code,      // Downstream code
    input wire logic       up_msg_vld,       // Upstream message strobe
    input wire logic [1:0] up_msg_addr,      // Upstream address
    input wire logic [3:0] up_msg_code,      // Upstream code
    input wire logic [7:0] up_msg_data,      // Upstream data
    input wire logic [7:0] dn_oh_bits,       // Downstream overhead
    input wire logic [7:0] up_oh_bits,       // Upstream overhead
    input wire logic       loop_closed_out,  // Loopback active
    input wire logic       cust_reset_out,   // Customer reset pulse
    input wire logic       net_side_on_out,  // Line side on
    input wire logic       cust_side_on_out, // Customer side on
    input wire logic       fwd_to_ntu_out    // Forwarding onward
);
    default clocking dclk @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    wire logic to_rep = dn_msg_vld && dn_msg_addr == rmlb_pkg::ADDR_REPEATER;
    wire logic to_other = dn_msg_vld && !to_rep;

    // ==========================================================
    // Loop handling
    loop_close_a: assert property (
        to_rep && dn_msg_code == rmlb_pkg::MSG_LOOP_REQ |=> loop_closed_out)
        else $error("loop did not close on request");
    loop_ack_a: assert property (
        to_rep && dn_msg_code == rmlb_pkg::MSG_LOOP_REQ |=> up_msg_vld
        && up_msg_addr == rmlb_pkg::ADDR_REPEATER
        && up_msg_code == rmlb_pkg::MSG_ACK)
        else $error("own address request not answered");
    wait_reply_a: assert property (
        loop_closed_out && to_other |=> up_msg_vld
        && up_msg_addr == rmlb_pkg::ADDR_REPEATER
        && up_msg_code == rmlb_pkg::MSG_WAIT_REPLY)
        else $error("foreign address not held off");
    loop_release_a: assert property (
        loop_closed_out && to_rep && dn_msg_code == rmlb_pkg::MSG_RESTORE
        |=> !loop_closed_out && !cust_side_on_out)
        else $error("restore did not cancel loop");
    cust_reset_a: assert property (
        $rose(loop_closed_out) |-> cust_reset_out)
        else $error("customer reset missing on loop");
    loop_transparent_a: assert property (
        loop_closed_out |-> fwd_to_ntu_out)
        else $error("looped signal not forwarded");
    looped_bits_a: assert property (
        loop_closed_out && $past(loop_closed_out) && $stable(dn_oh_bits)
        |-> up_oh_bits[7:4] == dn_oh_bits[7:4])
        else $error("indicator bits not looped");

    // ==========================================================
    // Faults and status
    both_sides_off_a: assert property (
        $fell(net_side_on_out) |-> !cust_side_on_out && !loop_closed_out)
        else $error("sides not deactivated together");
    status_data_a: assert property (
        to_rep && dn_msg_code == rmlb_pkg::MSG_STATUS_REQ |=> up_msg_vld
        && up_msg_code == rmlb_pkg::MSG_STATUS_RSP
        && up_msg_data[3:1] == $past({loop_closed_out, cust_side_on_out,
                                      net_side_on_out}))
        else $error("status reply wrong");
endmodule

// >>> verif/test_repeater_maintenance_loopback.sv
// Purpose: Self-checking bench joining controller and repeater
// Assumes: 10 MHz clock, deactivation count shortened to 20
// Notes:   Random config values and codes from a fixed seed
`timescale 1ns/1ns
module test_repeater_maintenance_loopback;
    logic       ref_clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic       net_fault_in = 1'b0;
    logic       cust_fault_in = 1'b0;
    logic       int_fail_in = 1'b0;
    logic       pwr_fail_one_in = 1'b0;
    logic       pwr_fail_two_in = 1'b0;
    logic       app_loss_in = 1'b0;
    logic       rx_blk_err_in = 1'b0;
    logic       cust_blk_err_in = 1'b0;
    logic [7:0] cust_oh_in = 8'h00;
    logic       net_side_on_out;
    logic       cust_side_on_out;
    logic       cust_reset_out;
    logic       loop_closed_out;
    logic       fwd_to_ntu_out;
    logic [7:0] cfg_out;
    logic [7:0] v;
    logic [1:0] a;
    int         seed;
    int         error_cnt = 0;
    int         tests_run = 0;

    always #50 ref_clk_in = ~ref_clk_in;

    rmlb_if lnk ();
    rmlb_line_term i_rmlb_line_term (.ref_clk_in, .rst_in, .lnk(lnk),
        .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out);
    // Short count keeps the persistence test to a few dozen cycles
    rmlb_repeater #(.DEACT_CYCLES(20), .APP_BITS_EN(1'b1)) i_rmlb_repeater (
        .ref_clk_in, .rst_in, .lnk(lnk), .net_fault_in, .cust_fault_in,
        .int_fail_in, .pwr_fail_one_in, .pwr_fail_two_in, .app_loss_in,
        .rx_blk_err_in, .cust_blk_err_in, .cust_oh_in, .net_side_on_out,
        .cust_side_on_out, .cust_reset_out, .loop_closed_out,
        .fwd_to_ntu_out, .cfg_out);
    rmlb_assertions i_rmlb_assertions (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .dn_msg_vld(lnk.dn_msg_vld),
        .dn_msg_addr(lnk.dn_msg_addr), .dn_msg_code(lnk.dn_msg_code),
        .up_msg_vld(lnk.up_msg_vld), .up_msg_addr(lnk.up_msg_addr),
        .up_msg_code(lnk.up_msg_code), .up_msg_data(lnk.up_msg_data),
        .dn_oh_bits(lnk.dn_oh_bits), .up_oh_bits(lnk.up_oh_bits),
        .loop_closed_out(loop_closed_out), .cust_reset_out(cust_reset_out),
        .net_side_on_out(net_side_on_out),
        .cust_side_on_out(cust_side_on_out),
        .fwd_to_ntu_out(fwd_to_ntu_out));

    // ==========================================================
    // Bus and check tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr_in <= ad;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] ad, input logic [7:0] exp);
        @(posedge ref_clk_in);
        addr_in <= ad;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp);
    endtask
    // Startup bit kept set so each request passes the controller's startup gate
    task automatic snd(input logic [1:0] ad, input logic [3:0] c);
        wr(rmlb_pkg::REG_CTRL, {2'b11, ad, c});
        cyc(4);
    endtask
    function automatic logic [7:0] rsp(input logic [3:0] c);
        return {c, 2'b00, rmlb_pkg::ADDR_REPEATER};
    endfunction
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(3000);
        error_cnt++;
        conclude();
    end

    // ==========================================================
    // Main sequence
    initial begin
        seed = 3582;
        cyc(6);
        rst_in <= 1'b0;
        cyc(1);
        chk(loop_closed_out, 1'b0);
        rdc(rmlb_pkg::REG_CFG, rmlb_pkg::CFG_RESET);
        // Neither startup nor live line: request must be dropped
        wr(rmlb_pkg::REG_CTRL, {2'b01, rmlb_pkg::ADDR_REPEATER, 4'h1});
        cyc(4);
        chk(loop_closed_out, 1'b0);
        rdc(rmlb_pkg::REG_RSP, 8'h00);
        snd(rmlb_pkg::ADDR_REPEATER, rmlb_pkg::MSG_LOOP_REQ);
        chk(loop_closed_out, 1'b1);
        rdc(rmlb_pkg::REG_RSP, rsp(rmlb_pkg::MSG_ACK));
        rdc(rmlb_pkg::REG_STATUS, 8'h03);
        for (int i = 0; i < 3; i++) begin
            a = (i == 2) ? 2'h3 : 2'(i);
            snd(a, 4'($random(seed)));
            rdc(rmlb_pkg::REG_RSP, rsp(rmlb_pkg::MSG_WAIT_REPLY));
        end
        snd(rmlb_pkg::ADDR_REPEATER, rmlb_pkg::MSG_STATUS_REQ);
        rdc(rmlb_pkg::REG_RSP, rsp(rmlb_pkg::MSG_STATUS_RSP));
        v = 8'($random(seed)) & 8'hF3;
        wr(rmlb_pkg::REG_CFG, v);
        rx_blk_err_in <= 1'b1;
        cust_blk_err_in <= 1'b1;
        snd(rmlb_pkg::ADDR_REPEATER, rmlb_pkg::MSG_CFG_WR);
        chk(cfg_out, v);
        chk(lnk.up_oh_bits[7:4], v[7:4]);
        chk(lnk.up_oh_bits[3:2], 2'b11);
        snd(rmlb_pkg::ADDR_REPEATER, rmlb_pkg::MSG_RESTORE);
        chk(loop_closed_out, 1'b0);
        chk(cust_side_on_out, 1'b1);
        rdc(rmlb_pkg::REG_STATUS, 8'h0F);
        // Unlooped: local alarm, power and application bits
        rx_blk_err_in <= 1'b0;
        cust_blk_err_in <= 1'b0;
        int_fail_in <= 1'b1;
        pwr_fail_one_in <= 1'b1;
        app_loss_in <= 1'b1;
        cyc(6);
        chk(lnk.up_oh_bits[rmlb_pkg::OH_REP_ALARM], 1'b1);
        chk(lnk.up_oh_bits[7:4], 4'hA);
        pwr_fail_one_in <= 1'b0;
        pwr_fail_two_in <= 1'b1;
        app_loss_in <= 1'b0;
        int_fail_in <= 1'b0;
        cyc(6);
        chk(lnk.up_oh_bits[7:4], 4'h4);
        snd(rmlb_pkg::ADDR_REPEATER, rmlb_pkg::MSG_LOOP_REQ);
        chk(loop_closed_out, 1'b1);
        // Persisting line fault with the loop still closed
        net_fault_in <= 1'b1;
        cyc(12);
        chk(net_side_on_out, 1'b1);
        cyc(25);
        chk(net_side_on_out, 1'b0);
        chk(cust_side_on_out, 1'b0);
        chk(loop_closed_out, 1'b0);
        net_fault_in <= 1'b0;
        wr(rmlb_pkg::REG_CTRL, 8'h00);
        wr(rmlb_pkg::REG_CTRL, 8'h80);
        cyc(4);
        chk(net_side_on_out, 1'b1);
        cust_fault_in <= 1'b1;
        cyc(40);
        chk(net_side_on_out, 1'b0);
        chk(cust_side_on_out, 1'b0);
        conclude();
    end
endmodule
